// File: inc/oam_pkg.sv
/*
  Constants and carrier types for the four-instruction execute block.
  Assumes a 14-bit instruction word and an 8-bit data path.
*/
// What this block does
// - Opcode 111000 in bits 13:8 decodes as OR literal into accumulator.
// - OR literal: acc OR literal goes back to acc; zero flag updated.
// - Opcode 000100, then destination bit, then 7-bit file address: OR with file.
// - OR with file: acc OR file register value; zero flag updated.
// - OR with file: destination bit 0 writes acc, 1 writes the file register.
// - Opcode 001000, then destination bit, then 7-bit address: move file register.
// - Move: bit 0 copies file value to acc; bit 1 rewrites it unchanged.
// - Move updates zero flag from the moved value for both destinations.
// - Load literal places literal in acc and leaves flags alone.
// - Either value of the two ignored load-literal bits is accepted.
package oam_pkg;
  localparam int         INSTR_W       = 14;
  localparam int         DATA_W        = 8;
  localparam int         ADDR_W        = 7;
  localparam int         DEST_BIT      = 7;
  localparam logic [5:0] OPC_OR_LIT    = 6'h38;
  localparam logic [5:0] OPC_OR_FILE   = 6'h04;
  localparam logic [5:0] OPC_MOVE_FILE = 6'h08;
  localparam logic [3:0] OPC_LOAD_LIT  = 4'hC;
  localparam logic [7:0] ACC_RESET     = 8'h00;
  localparam logic       ZERO_RESET    = 1'b0;

  typedef enum logic [2:0] {
    OAM_OP_NONE      = 3'b000,
    OAM_OP_OR_LIT    = 3'b001,
    OAM_OP_OR_FILE   = 3'b010,
    OAM_OP_MOVE_FILE = 3'b011,
    OAM_OP_LOAD_LIT  = 3'b100
  } oam_op_e;

  typedef struct packed {
    oam_op_e     op;
    logic        dest_file;
    logic [6:0]  addr;
    logic [7:0]  lit;
  } oam_dec_s;

  typedef struct packed {
    logic        we;
    logic [6:0]  addr;
    logic [7:0]  data;
  } oam_fwr_s;
endpackage

// File: logic/oam_decode.sv
/*
  Pure decoder of one 14-bit instruction word into an operation and fields.
  Assumes the caller gates the decoded operation with instr_valid itself.
*/
module oam_decode
  import oam_pkg::*;
(
  input  wire logic [13:0] instr,
  output oam_dec_s         dec
);
  always_comb begin
    dec.dest_file = instr[DEST_BIT];
    dec.addr      = instr[6:0];
    dec.lit       = instr[7:0];
    if (instr[13:8] == OPC_OR_LIT) begin
      dec.op = OAM_OP_OR_LIT;
    end else if (instr[13:8] == OPC_OR_FILE) begin
      dec.op = OAM_OP_OR_FILE;
    end else if (instr[13:8] == OPC_MOVE_FILE) begin
      dec.op = OAM_OP_MOVE_FILE;
    end else if (instr[13:10] == OPC_LOAD_LIT) begin
      // bits 9:8 not looked at
      dec.op = OAM_OP_LOAD_LIT;
    end else begin
      dec.op = OAM_OP_NONE;
    end
  end
endmodule

// File: logic/oam_exec.sv
/*
  Execute stage for the OR-literal, OR-file, move-file and load-literal words.
  Assumes the core presents one instruction per instr_valid pulse (one per
  instruction cycle) and returns the addressed file register combinationally
  on file_rdata from file_raddr in the same cycle.
*/
module oam_exec
  import oam_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        instr_valid,
  input  wire logic [13:0] instr,
  output logic      [6:0]  file_raddr,
  input  wire logic [7:0]  file_rdata,
  output oam_fwr_s         file_wr,
  output logic      [7:0]  acc,
  output logic             zero_flag,
  output logic             handled,
  output logic             discard_next
);
  // ==========================================================
  // decode and combinational result
  oam_dec_s   dec;
  logic [7:0] result;
  logic       hit;
  logic       next_zero_we;
  logic       next_acc_we;
  logic       next_file_we;

  oam_decode u_dec (
    .instr (instr),
    .dec   (dec)
  );

  assign file_raddr = dec.addr;
  assign hit        = instr_valid && (dec.op != OAM_OP_NONE);
  // never a skip: prefetch always kept
  assign discard_next = 1'b0;

  always_comb begin
    result       = 8'h00;
    next_zero_we = 1'b0;
    next_acc_we  = 1'b0;
    next_file_we = 1'b0;
    unique case (dec.op)
      OAM_OP_OR_LIT: begin
        result       = acc | dec.lit;
        next_zero_we = 1'b1;
        next_acc_we  = 1'b1;
      end
      OAM_OP_OR_FILE: begin
        result       = acc | file_rdata;
        next_zero_we = 1'b1;
        next_acc_we  = !dec.dest_file;
        next_file_we = dec.dest_file;
      end
      OAM_OP_MOVE_FILE: begin
        result       = file_rdata;
        next_zero_we = 1'b1;
        next_acc_we  = !dec.dest_file;
        next_file_we = dec.dest_file;
      end
      OAM_OP_LOAD_LIT: begin
        result       = dec.lit;
        next_acc_we  = 1'b1;
      end
      OAM_OP_NONE: begin
        result       = 8'h00;
      end
    endcase
  end

  // ==========================================================
  // accumulator
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc <= ACC_RESET;
    end else if (hit && next_acc_we) begin
      acc <= result;
    end
  end

  // ==========================================================
  // zero flag; load literal leaves it alone
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      zero_flag <= ZERO_RESET;
    end else if (hit && next_zero_we) begin
      zero_flag <= (result == 8'h00);
    end
  end

  // ==========================================================
  // file write-back, registered so data comes from flops
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      file_wr <= '0;
      handled <= 1'b0;
    end else begin
      file_wr.we   <= hit && next_file_we;
      file_wr.addr <= dec.addr;
      file_wr.data <= result;
      handled      <= hit;
    end
  end

  // ==========================================================
  // opcode match for the checks only; kept apart from oam_decode so a
  // slip in the decoder shows up instead of being mirrored
  logic chk_or_lit;
  logic chk_or_file;
  logic chk_move;
  logic chk_load;
  logic chk_known;
  logic chk_zero_op;
  logic chk_acc_op;

  assign chk_or_lit  = (instr[13:8] == OPC_OR_LIT);
  assign chk_or_file = (instr[13:8] == OPC_OR_FILE);
  assign chk_move    = (instr[13:8] == OPC_MOVE_FILE);
  // bits 9:8 left out on purpose
  assign chk_load    = (instr[13:10] == OPC_LOAD_LIT);
  assign chk_known   = chk_or_lit || chk_or_file || chk_move || chk_load;
  assign chk_zero_op = instr_valid && (chk_or_lit || chk_or_file || chk_move);
  assign chk_acc_op  = instr_valid && (chk_or_lit || chk_load
                       || ((chk_or_file || chk_move) && !instr[DEST_BIT]));

  // ==========================================================
  // checks
  sequence or_lit_s;
    instr_valid && instr[13:8] == OPC_OR_LIT;
  endsequence

  sequence or_file_s;
    instr_valid && chk_or_file;
  endsequence

  sequence move_s;
    instr_valid && chk_move;
  endsequence

  sequence load_s;
    instr_valid && chk_load;
  endsequence

  sequence known_s;
    instr_valid && chk_known;
  endsequence

  // second step of every accepted word: done, prefetch kept
  sequence done_s;
    handled ##0 !discard_next;
  endsequence

  or_lit_acc_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    or_lit_s |=> acc == ($past(acc) | $past(instr[7:0])))
    else $error("or literal result wrong");

  or_lit_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    or_lit_s |=> zero_flag == ((($past(acc) | $past(instr[7:0]))) == 8'h00))
    else $error("or literal zero flag wrong");

  or_file_acc_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    instr_valid && instr[13:8] == OPC_OR_FILE && !instr[7]
    |=> acc == ($past(acc) | $past(file_rdata)) && !file_wr.we)
    else $error("or file to acc wrong");

  or_file_wr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    instr_valid && instr[13:8] == OPC_OR_FILE && instr[7]
    |=> file_wr.we && file_wr.data == ($past(acc) | $past(file_rdata))
        && acc == $past(acc))
    else $error("or file write-back wrong");

  move_acc_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    instr_valid && instr[13:8] == OPC_MOVE_FILE && !instr[7]
    |=> acc == $past(file_rdata))
    else $error("move to acc wrong");

  move_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    instr_valid && instr[13:8] == OPC_MOVE_FILE
    |=> zero_flag == ($past(file_rdata) == 8'h00))
    else $error("move zero flag wrong");

  load_lit_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    instr_valid && instr[13:10] == OPC_LOAD_LIT
    |=> acc == $past(instr[7:0]) && $stable(zero_flag) && !file_wr.we)
    else $error("load literal wrong");

  one_cycle_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    known_s |=> done_s)
    else $error("instruction not done in one cycle");

  no_op_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !instr_valid |=> $stable(acc) && $stable(zero_flag) && !file_wr.we && !handled)
    else $error("state changed without instruction");

  refused_op_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    instr_valid && !chk_known
    |=> $stable(acc) && $stable(zero_flag) && !file_wr.we && !handled)
    else $error("unrecognised word changed state");

  or_file_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    or_file_s |=> zero_flag == (($past(acc) | $past(file_rdata)) == 8'h00))
    else $error("or file zero flag wrong");

  or_file_addr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    or_file_s ##0 instr[DEST_BIT] |=> file_wr.addr == $past(instr[6:0]))
    else $error("or file write address wrong");

  move_file_wr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    move_s ##0 instr[DEST_BIT]
    |=> file_wr.we && file_wr.addr == $past(instr[6:0])
        && file_wr.data == $past(file_rdata) && acc == $past(acc))
    else $error("move write-back wrong");

  load_dont_care_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    load_s ##0 (instr[9:8] != 2'b00) |=> handled && acc == $past(instr[7:0]))
    else $error("load literal with set ignored bits wrong");

  read_addr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    instr_valid |-> file_raddr == instr[6:0])
    else $error("file read address wrong");

  zero_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $changed(zero_flag) |-> $past(chk_zero_op))
    else $error("zero flag changed without a flag-writing instruction");

  acc_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $changed(acc) |-> $past(chk_acc_op))
    else $error("accumulator changed without an accumulator write");
endmodule

// File: bench/tb.sv
/*
  Self-checking bench for the four-instruction execute block.
  Assumes oam_pkg is compiled first; the bench forwards file writes.
*/
module tb
  import oam_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic       h;
    logic       z;
    logic [7:0] acc;
    oam_fwr_s   wr;
  } oam_note_s;
  logic        core_clk;
  logic        rst_n;
  logic        instr_valid;
  logic [13:0] instr;
  logic [13:0] rw;
  logic [6:0]  file_raddr;
  logic [7:0]  file_rdata;
  oam_fwr_s    file_wr;
  logic [7:0]  acc;
  logic        zero_flag;
  logic        handled;
  logic        discard_next;
  logic [7:0]  mem [128];
  logic [7:0]  m_acc;
  logic        m_z;
  oam_note_s   q [$];
  oam_note_s   got;
  int          miscompares;
  int          checks;
  oam_exec DUT (.core_clk(core_clk), .rst_n(rst_n), .instr_valid(instr_valid),
    .instr(instr), .file_raddr(file_raddr), .file_rdata(file_rdata), .file_wr(file_wr),
    .acc(acc), .zero_flag(zero_flag), .handled(handled), .discard_next(discard_next));
  // model holds writes at once: stands in for the core's forwarding
  assign file_rdata = mem[file_raddr];
  // ==========
  // check, drive, close
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic run(input logic [13:0] w, input logic v);
    logic [7:0] r;
    oam_note_s  n;
    r = w[13] ? (m_acc | w[7:0]) : (w[10] ? (m_acc | mem[w[6:0]]) : mem[w[6:0]]);
    n = '{h: v, z: m_z, acc: m_acc, wr: '0};
    casez ({v, w[13:8]})
      7'b1_111000, 7'b1_000100, 7'b1_001000: begin
        n.z = (r == 8'h00);
        if (w[7] && !w[13]) n.wr = {1'b1, w[6:0], r};
        else n.acc = r;
      end
      7'b1_1100??: n.acc = w[7:0];
      default: n.h = 1'b0;
    endcase
    instr <= w;
    instr_valid <= v;
    @(posedge core_clk);
    #1;
    q.push_back(n);
    m_acc = n.acc;
    m_z = n.z;
    if (n.wr.we) mem[n.wr.addr] = n.wr.data;
  endtask
  task automatic end_of_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ==========
  // clock, monitor, watchdog
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial forever begin
    @(posedge core_clk);
    #2;
    chk("discard_next", 16'(discard_next), 16'h0000);
    chk("file_raddr", 16'(file_raddr), 16'(instr[6:0]));
    if (q.size() > 0) begin
      got = q.pop_front();
      chk("handled", 16'(handled), 16'(got.h));
      chk("acc", 16'(acc), 16'(got.acc));
      chk("zero_flag", 16'(zero_flag), 16'(got.z));
      chk("file_wr", file_wr.we ? 16'(file_wr) : 16'h0000, 16'(got.wr));
    end
  end
  initial begin
    #10000;
    miscompares++;
    end_of_test();
  end
  // ==========
  // tests
  initial begin
    rst_n = 1'b0;
    instr_valid = 1'b0;
    instr = 14'h0000;
    m_acc = ACC_RESET;
    m_z = ZERO_RESET;
    void'($urandom(1));
    foreach (mem[i]) mem[i] = 8'($urandom);
    repeat (10) @(posedge core_clk);
    #1;
    chk("reset_state", 16'({acc, zero_flag, handled}), 16'h0000);
    rst_n <= 1'b1;
    mem[7'h13] = 8'h13;
    run(14'h309A, 1'b1);
    run(14'h3835, 1'b1);
    run(14'h3091, 1'b1);
    run(14'h0413, 1'b1);
    run(14'h3091, 1'b1);
    run(14'h0493, 1'b1);
    run(14'h0893, 1'b1);
    run(14'h0813, 1'b1);
    $display("test back_to_back done");
    mem[7'h05] = 8'h00;
    run(14'h3000, 1'b1);
    run(14'h3800, 1'b1);
    run(14'h0885, 1'b1);
    run(14'h31FF, 1'b1);
    run(14'h32FF, 1'b1);
    run(14'h33FF, 1'b1);
    run(14'h0805, 1'b1);
    run(14'h0405, 1'b1);
    $display("test zero_and_dont_care done");
    run(14'h3855, 1'b0);
    run(14'h0A13, 1'b1);
    run(14'h3F00, 1'b1);
    run(14'h0013, 1'b1);
    $display("test refused done");
    repeat (300) begin
      rw = 14'($urandom);
      case ($urandom % 5)
        0: rw[13:8] = 6'h38;
        1: rw[13:8] = 6'h04;
        2: rw[13:8] = 6'h08;
        3: rw[13:10] = 4'hC;
        default: ;
      endcase
      run(rw, 1'($urandom % 8 != 0));
    end
    $display("test random done");
    run(14'h0000, 1'b0);
    @(posedge core_clk);
    #3;
    end_of_test();
  end
endmodule
